// [can_wake_pkg.sv]
// Constants, modes and rule summary for the transceiver control link
// Function
// (R1) Transmit input pulled up, undriven means recessive
// (R2) Normal mode: receive output mirrors bus state
// (R3) Transceiver supply off holds receive low
// (R4) Command picks one of four slew settings
// (R5) Slew setting changes transmit and receive delay
// (R6) Long dominant transmit switches driver off
// (R7) Controller keeps bit rate above about 60k
// (R8) Unpowered modes: supply off, pins low
// (R9) Standby on logic supply acts like normal
// (R10) Low power: drivers off, fifty kilohm termination
// (R11) Wake receiver only when wake enabled
// (R12) Controller enables wake before commanding sleep
// (R13) Sleep without wake ignores bus traffic
// (R14) Back to normal: bus returns recessive
// (R15) Chip sleep wake turns logic supply on
// (R16) Chip stop wake gives interrupt pulse
// (R17) Normal or standby wake sets wake flag
// (R18) Software checks wake flag before low power
// (R19) Flag holds until normal command and read
// (R20) Wake needs three valid dominant pulses
// (R21) Gap and window limits, else restart
// (R22) Transmit high recessive, low dominant
// (R23) Driver re-enabled when transmit returns high
// (R24) Pattern checks counted on reference clock
package can_wake_pkg;
	localparam int CLK_NS = 100;
	localparam int DOM_TIMEOUT_NS = 200000;
	localparam int PULSE_MIN_NS = 500;
	localparam int PULSE_MAX_NS = 500000;
	localparam int GAP_MAX_NS = 500000;
	localparam int WINDOW_NS = 1000000;
	// Dominant timeout rounds up, all other times round down
	localparam int DOM_CYC = (DOM_TIMEOUT_NS + CLK_NS - 1) / CLK_NS;
	localparam int PULSE_MIN_CYC = PULSE_MIN_NS / CLK_NS;
	localparam int PULSE_MAX_CYC = PULSE_MAX_NS / CLK_NS;
	localparam int GAP_MAX_CYC = GAP_MAX_NS / CLK_NS;
	localparam int WINDOW_CYC = WINDOW_NS / CLK_NS;
	localparam int CNT_W = 14;
	localparam int DOM_W = 12;
	localparam int WAKE_PULSES = 3;
	localparam int SLEW_N = 4;
	localparam logic [3:0] CTRL_OFS = 4'h0;
	localparam logic [3:0] TXD_OFS = 4'h4;
	localparam logic [3:0] STAT_OFS = 4'h8;
	localparam int CTRL_MODE_BIT = 0;
	localparam int CTRL_SLEW_LSB = 1;
	localparam int CTRL_WAKE_BIT = 3;
	localparam int TXD_LEVEL_BIT = 0;
	localparam int TXD_OE_BIT = 1;
	localparam logic [1:0] SLEW_RST = 2'h0;
	typedef enum logic [2:0] {
		CHIP_RESET = 3'b000,
		CHIP_NREQ = 3'b001,
		CHIP_NORMAL = 3'b010,
		CHIP_STANDBY = 3'b011,
		CHIP_STOP = 3'b100,
		CHIP_SLEEP = 3'b101
	} chip_mode_t;
	typedef enum logic {
		XCVR_NORMAL = 1'b0,
		XCVR_SLEEP = 1'b1
	} xcvr_mode_t;
endpackage : can_wake_pkg

// [can_link_if.sv]
// Link between transceiver control and its controller
`timescale 1ns/10ps
interface can_link_if
	import can_wake_pkg::*;
	;
	logic tx_drv;
	logic tx_oe;
	logic tx;
	logic rx;
	logic cmd_valid;
	xcvr_mode_t cmd_mode;
	logic [1:0] cmd_slew;
	logic cmd_wake_en;
	logic stat_rd;
	logic wake_flag;
	logic tx_fail;
	// Weak pull-up wins when nobody drives the pin
	assign tx = tx_oe ? tx_drv : 1'b1; // (R1)
	modport dev (
		input tx,
		input cmd_valid,
		input cmd_mode,
		input cmd_slew,
		input cmd_wake_en,
		input stat_rd,
		output rx,
		output wake_flag,
		output tx_fail
	);
	modport host (
		output tx_drv,
		output tx_oe,
		output cmd_valid,
		output cmd_mode,
		output cmd_slew,
		output cmd_wake_en,
		output stat_rd,
		input rx,
		input wake_flag,
		input tx_fail
	);
endinterface : can_link_if

// [can_xcvr_dev.sv]
// Transceiver mode, timeout and pattern wake-up logic
`timescale 1ns/10ps
module can_xcvr_dev
	import can_wake_pkg::*;
#(
	parameter logic [CNT_W-1:0] PULSE_MAX = CNT_W'(PULSE_MAX_CYC),
	parameter logic [CNT_W-1:0] GAP_MAX = CNT_W'(GAP_MAX_CYC),
	parameter logic [CNT_W-1:0] WINDOW_MAX = CNT_W'(WINDOW_CYC)
) (
	input wire logic ref_clk,
	input wire logic rst_n,
	can_link_if.dev lnk,
	input wire chip_mode_t chip_mode,
	input wire logic ext_ballast,
	input wire logic bus_dominant,
	output logic xcvr_supply_on,
	output logic logic_supply_on,
	output logic drv_enable,
	output logic drv_dominant,
	output logic bias_recessive,
	output logic term_50k,
	output logic wake_rx_on,
	output logic int_pulse,
	output logic [1:0] slew_sel
);
	typedef struct packed {
		logic bus_s1;
		logic bus_s2;
		logic [SLEW_N-1:0] tx_pipe;
		logic [SLEW_N-1:0] rx_pipe;
		xcvr_mode_t xmode;
		logic [1:0] slew;
		logic wake_en;
		logic [DOM_W-1:0] dom_cnt;
		logic txf;
		logic flag;
		logic read_seen;
		logic norm_seen;
		logic prev_dom;
		logic [CNT_W-1:0] pw_cnt;
		logic [CNT_W-1:0] gap_cnt;
		logic [CNT_W-1:0] win_cnt;
		logic [1:0] pulses;
		logic lsup_wake;
		logic rx;
		logic xsup_on;
		logic lsup_on;
		logic drv_en;
		logic drv_dom;
		logic bias;
		logic term;
		logic wake_rx;
		logic int_p;
	} dev_state_t;

	dev_state_t cur_ff;
	dev_state_t nxt_st;

	always_comb begin
		logic xsup;
		logic xnorm;
		logic tx_eff;
		logic tx_tap;
		logic active;
		logic wake;
		logic restart;
		xsup = 1'b0;
		xnorm = 1'b0;
		tx_eff = 1'b1;
		tx_tap = 1'b1;
		active = 1'b0;
		wake = 1'b0;
		restart = 1'b0;
		nxt_st = cur_ff;
		nxt_st.int_p = 1'b0;
		// Bus pin comes from outside the clock domain
		nxt_st.bus_s1 = bus_dominant;
		nxt_st.bus_s2 = cur_ff.bus_s1;
		if (lnk.cmd_valid) begin
			nxt_st.xmode = lnk.cmd_mode;
			nxt_st.slew = lnk.cmd_slew; // (R4)
			nxt_st.wake_en = lnk.cmd_wake_en;
			if (lnk.cmd_mode == XCVR_NORMAL) begin
				nxt_st.norm_seen = 1'b1;
			end
		end
		if (lnk.stat_rd) begin
			nxt_st.read_seen = 1'b1;
		end
		unique case (chip_mode)
			CHIP_NORMAL: xsup = 1'b1;
			CHIP_STANDBY: xsup = ~ext_ballast; // (R9)
			CHIP_RESET, CHIP_NREQ, CHIP_STOP, CHIP_SLEEP: xsup = 1'b0; // (R8)
			default: xsup = 1'b0;
		endcase
		xnorm = (cur_ff.xmode == XCVR_NORMAL);
		// Pin reads low while its supply is down
		tx_eff = xsup & lnk.tx; // (R8)
		nxt_st.tx_pipe = {cur_ff.tx_pipe[SLEW_N-2:0], tx_eff};
		nxt_st.rx_pipe = {cur_ff.rx_pipe[SLEW_N-2:0], cur_ff.bus_s2};
		// Slower slew costs more loop delay
		tx_tap = cur_ff.tx_pipe[cur_ff.slew]; // (R5)
		// Dominant timeout, cleared as soon as transmit is high
		// A dead supply is not a dominant request
		if (!tx_eff && xnorm && xsup) begin
			if (cur_ff.dom_cnt >= DOM_W'(DOM_CYC - 1)) begin
				nxt_st.txf = 1'b1; // (R6)
			end else begin
				nxt_st.dom_cnt = cur_ff.dom_cnt + 1'b1;
			end
		end else begin
			nxt_st.dom_cnt = '0;
			nxt_st.txf = 1'b0; // (R23)
		end
		nxt_st.xsup_on = xsup;
		nxt_st.drv_en = xsup & xnorm & ~cur_ff.txf; // (R6)
		nxt_st.drv_dom = xsup & xnorm & ~cur_ff.txf & ~tx_tap; // (R22)
		nxt_st.bias = xsup & xnorm & ~nxt_st.drv_dom; // (R14)
		nxt_st.term = ~(xsup & xnorm); // (R10)
		if (!xsup) begin
			nxt_st.rx = 1'b0; // (R3)
		end else if (xnorm) begin
			nxt_st.rx = ~cur_ff.rx_pipe[cur_ff.slew]; // (R2)
		end else begin
			nxt_st.rx = 1'b1; // (R9)
		end
		// Pattern detector runs only in sleep with wake enabled
		active = ~xnorm & cur_ff.wake_en; // (R11) (R13)
		nxt_st.wake_rx = active;
		nxt_st.prev_dom = cur_ff.bus_s2;
		if (active) begin
			if (cur_ff.pulses != 2'd0 || cur_ff.pw_cnt != '0) begin
				nxt_st.win_cnt = cur_ff.win_cnt + 1'b1;
				if (cur_ff.win_cnt >= WINDOW_MAX - 1'b1) begin
					restart = 1'b1; // (R21)
				end
			end
			if (cur_ff.bus_s2) begin
				nxt_st.gap_cnt = '0;
				nxt_st.pw_cnt = cur_ff.pw_cnt + 1'b1; // (R24)
				if (cur_ff.pw_cnt >= PULSE_MAX - 1'b1) begin
					restart = 1'b1; // (R20)
				end
			end else begin
				nxt_st.pw_cnt = '0;
				if (cur_ff.pulses != 2'd0) begin
					nxt_st.gap_cnt = cur_ff.gap_cnt + 1'b1; // (R24)
					if (cur_ff.gap_cnt >= GAP_MAX - 1'b1) begin
						restart = 1'b1; // (R21)
					end
				end
				if (cur_ff.prev_dom) begin
					if (cur_ff.pw_cnt > CNT_W'(PULSE_MIN_CYC)) begin
						if (cur_ff.pulses == 2'(WAKE_PULSES - 1)) begin
							wake = 1'b1; // (R20)
						end else begin
							nxt_st.pulses = cur_ff.pulses + 1'b1;
						end
					end else begin
						restart = 1'b1; // (R20)
					end
				end
			end
		end else begin
			restart = 1'b1;
		end
		if (restart || wake) begin
			nxt_st.pw_cnt = '0;
			nxt_st.gap_cnt = '0;
			nxt_st.win_cnt = '0;
			nxt_st.pulses = 2'd0;
		end
		// Clear needs both a normal command and a read
		if (cur_ff.flag && cur_ff.norm_seen && cur_ff.read_seen) begin
			nxt_st.flag = 1'b0; // (R19)
			nxt_st.norm_seen = 1'b0;
			nxt_st.read_seen = 1'b0;
		end
		// A new wake outranks a clear in the same cycle
		if (wake) begin
			nxt_st.flag = 1'b1; // (R17)
			nxt_st.norm_seen = 1'b0;
			nxt_st.read_seen = 1'b0;
			if (chip_mode == CHIP_SLEEP) begin
				nxt_st.lsup_wake = 1'b1; // (R15)
			end
			if (chip_mode == CHIP_STOP) begin
				nxt_st.int_p = 1'b1; // (R16)
			end
		end else if (chip_mode != CHIP_SLEEP) begin
			nxt_st.lsup_wake = 1'b0;
		end
		nxt_st.lsup_on = (chip_mode != CHIP_SLEEP) | nxt_st.lsup_wake; // (R15)
	end

	always_ff @(posedge ref_clk) begin
		if (!rst_n) begin
			cur_ff <= '0;
			cur_ff.xmode <= XCVR_NORMAL;
			cur_ff.slew <= SLEW_RST;
			cur_ff.tx_pipe <= '1;
			cur_ff.term <= 1'b1;
			cur_ff.lsup_on <= 1'b1;
		end else begin
			cur_ff <= nxt_st;
		end
	end

	assign lnk.rx = cur_ff.rx;
	assign lnk.wake_flag = cur_ff.flag;
	assign lnk.tx_fail = cur_ff.txf;
	assign xcvr_supply_on = cur_ff.xsup_on;
	assign logic_supply_on = cur_ff.lsup_on;
	assign drv_enable = cur_ff.drv_en;
	assign drv_dominant = cur_ff.drv_dom;
	assign bias_recessive = cur_ff.bias;
	assign term_50k = cur_ff.term;
	assign wake_rx_on = cur_ff.wake_rx;
	assign int_pulse = cur_ff.int_p;
	assign slew_sel = cur_ff.slew;
endmodule : can_xcvr_dev

// [can_xcvr_host.sv]
// Controller end: command registers, transmit level and status
`timescale 1ns/10ps
module can_xcvr_host
	import can_wake_pkg::*;
(
	input wire logic ref_clk,
	input wire logic rst_n,
	can_link_if.host lnk,
	input wire logic [3:0] addr,
	input wire logic [7:0] wdata,
	input wire logic wr,
	input wire logic rd,
	output logic [7:0] rdata
);
	typedef struct packed {
		logic tx_drv;
		logic tx_oe;
		logic cmd_valid;
		xcvr_mode_t cmd_mode;
		logic [1:0] slew;
		logic wake_en;
		logic stat_rd;
		logic pend_sleep;
		logic [7:0] rdata;
	} host_state_t;

	host_state_t cur_ff;
	host_state_t nxt_st;

	always_comb begin
		nxt_st = cur_ff;
		nxt_st.cmd_valid = 1'b0;
		nxt_st.stat_rd = 1'b0;
		nxt_st.rdata = 8'h00;
		// Second half of a sleep request goes out once wake is set
		if (cur_ff.pend_sleep) begin
			nxt_st.pend_sleep = 1'b0;
			nxt_st.cmd_valid = 1'b1;
			nxt_st.cmd_mode = XCVR_SLEEP; // (R12)
		end
		if (wr && addr == CTRL_OFS) begin
			nxt_st.slew = wdata[CTRL_SLEW_LSB +: 2]; // (R4)
			nxt_st.wake_en = wdata[CTRL_WAKE_BIT];
			nxt_st.cmd_valid = 1'b1;
			if (wdata[CTRL_MODE_BIT]) begin
				// Keep current mode this cycle so wake lands first
				nxt_st.cmd_mode = cur_ff.cmd_mode; // (R12)
				nxt_st.pend_sleep = 1'b1;
			end else begin
				nxt_st.cmd_mode = XCVR_NORMAL;
				nxt_st.pend_sleep = 1'b0;
			end
		end
		if (wr && addr == TXD_OFS) begin
			nxt_st.tx_drv = wdata[TXD_LEVEL_BIT];
			nxt_st.tx_oe = wdata[TXD_OE_BIT];
		end
		if (rd) begin
			unique case (addr)
				CTRL_OFS: nxt_st.rdata = {4'h0, cur_ff.wake_en, cur_ff.slew, cur_ff.cmd_mode};
				TXD_OFS: nxt_st.rdata = {6'h00, cur_ff.tx_oe, cur_ff.tx_drv};
				STAT_OFS: begin
					nxt_st.rdata = {5'h00, lnk.tx_fail, lnk.wake_flag, lnk.rx}; // (R18)
					nxt_st.stat_rd = 1'b1; // (R19)
				end
				default: nxt_st.rdata = 8'h00;
			endcase
		end
	end

	always_ff @(posedge ref_clk) begin
		if (!rst_n) begin
			cur_ff <= '0;
			cur_ff.cmd_mode <= XCVR_NORMAL;
			cur_ff.slew <= SLEW_RST;
		end else begin
			cur_ff <= nxt_st;
		end
	end

	assign lnk.tx_drv = cur_ff.tx_drv;
	assign lnk.tx_oe = cur_ff.tx_oe;
	assign lnk.cmd_valid = cur_ff.cmd_valid;
	assign lnk.cmd_mode = cur_ff.cmd_mode;
	assign lnk.cmd_slew = cur_ff.slew;
	assign lnk.cmd_wake_en = cur_ff.wake_en;
	assign lnk.stat_rd = cur_ff.stat_rd;
	assign rdata = cur_ff.rdata;
endmodule : can_xcvr_host

// [can_link_sva.sv]
// Checker for the signals of the transceiver control link
`timescale 1ns/10ps
module can_link_sva
	import can_wake_pkg::*;
(
	input wire logic ref_clk,
	input wire logic rst_n,
	input wire logic tx_drv,
	input wire logic tx_oe,
	input wire logic tx,
	input wire logic cmd_valid,
	input wire xcvr_mode_t cmd_mode,
	input wire logic [1:0] cmd_slew,
	input wire logic cmd_wake_en,
	input wire logic stat_rd,
	input wire logic wake_flag,
	input wire logic tx_fail
);
	default clocking @(posedge ref_clk); endclocking
	default disable iff (!rst_n);
	logic [11:0] low_ff;
	logic norm_ff;
	logic rd_ff;
	// Only events after the wake count towards clearing it
	always_ff @(posedge ref_clk) begin
		low_ff <= (!rst_n || tx) ? 12'h000 : low_ff + 12'h001;
		norm_ff <= rst_n && wake_flag && (norm_ff || (cmd_valid && cmd_mode == XCVR_NORMAL));
		rd_ff <= rst_n && wake_flag && (rd_ff || stat_rd);
	end
	sequence dom_run;
		(!tx) [*8];
	endsequence
	a_pull_up_idle: assert property (!tx_oe |-> tx)
		else $error("undriven transmit pin not high");
	a_tx_follows: assert property (tx_oe |-> tx == tx_drv)
		else $error("transmit pin differs from driven level");
	a_fail_min_low: assert property ($rose(tx_fail) |-> low_ff >= 12'(DOM_CYC))
		else $error("timeout flagged too early");
	a_fail_holds: assert property (dom_run ##0 tx_fail |=> tx_fail)
		else $error("timeout dropped while still dominant");
	a_fail_release: assert property (tx_fail && tx |-> ##[1:6] !tx_fail)
		else $error("timeout not released after recessive");
	a_flag_clear: assert property ($fell(wake_flag) |-> norm_ff && rd_ff)
		else $error("wake flag cleared too soon");
	a_sleep_order: assert property ($rose(cmd_mode == XCVR_SLEEP) |-> cmd_valid && $stable(cmd_wake_en))
		else $error("sleep sent together with wake change");
	a_slew_by_cmd: assert property ($changed(cmd_slew) |-> cmd_valid)
		else $error("slew changed without command");
	a_wake_by_cmd: assert property ($changed(cmd_wake_en) |-> cmd_valid)
		else $error("wake enable changed without command");
endmodule : can_link_sva

// [can_transceiver_mode_and_wake_tb.sv]
// Bench joining both ends of the transceiver link
`timescale 1ns/10ps
module can_transceiver_mode_and_wake_tb;
	import can_wake_pkg::*;
	logic ref_clk, rst_n, wr, rd, ext_ballast, bus_dom;
	logic [3:0] addr;
	logic [7:0] wdata, rdata, r;
	logic [1:0] slew;
	chip_mode_t chip_mode;
	logic sup_on, lsup_on, drv_en, drv_dom, bias, term, wrx, int_pulse;
	int errors, checks_done, i, n;
	can_link_if lnk ();
	// Short pattern limits keep the wake runs brief
	can_xcvr_dev #(.PULSE_MAX(14'h0028), .GAP_MAX(14'h0028), .WINDOW_MAX(14'h0064))
		can_xcvr_dev_inst (.ref_clk(ref_clk), .rst_n(rst_n), .lnk(lnk), .chip_mode(chip_mode),
		.ext_ballast(ext_ballast), .bus_dominant(bus_dom), .xcvr_supply_on(sup_on),
		.logic_supply_on(lsup_on), .drv_enable(drv_en), .drv_dominant(drv_dom),
		.bias_recessive(bias), .term_50k(term), .wake_rx_on(wrx), .int_pulse(int_pulse),
		.slew_sel(slew));
	can_xcvr_host can_xcvr_host_inst (.ref_clk(ref_clk), .rst_n(rst_n), .lnk(lnk), .addr(addr),
		.wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata));
	can_link_sva can_link_sva_inst (.ref_clk(ref_clk), .rst_n(rst_n), .tx_drv(lnk.tx_drv),
		.tx_oe(lnk.tx_oe), .tx(lnk.tx), .cmd_valid(lnk.cmd_valid), .cmd_mode(lnk.cmd_mode),
		.cmd_slew(lnk.cmd_slew), .cmd_wake_en(lnk.cmd_wake_en), .stat_rd(lnk.stat_rd),
		.wake_flag(lnk.wake_flag), .tx_fail(lnk.tx_fail));
	task automatic final_report;
		$display("Checks %0d, mismatches %0d", checks_done, errors);
		if (errors == 0 && checks_done > 0) begin
			$display("Simulation passed");
		end else begin
			$display("Simulation failed");
		end
		$finish;
	endtask : final_report
	task automatic chk(input logic [7:0] got, input logic [7:0] exp);
		checks_done++;
		if (got !== exp) begin
			errors++;
			$display("Error at %0t: got %h expected %h", $time, got, exp);
		end
	endtask : chk
	task automatic lim(input int k, input int m);
		if (k >= m) begin
			errors++;
			$display("Error at %0t: wait ran out", $time);
			final_report();
		end
	endtask : lim
	task automatic wt(input int k);
		repeat (k) @(posedge ref_clk);
		#1;
	endtask : wt
	task automatic wr_reg(input logic [3:0] a, input logic [7:0] d);
		@(posedge ref_clk);
		addr <= a;
		wdata <= d;
		wr <= 1'h1;
		@(posedge ref_clk);
		wr <= 1'h0;
	endtask : wr_reg
	task automatic rd_reg(input logic [3:0] a);
		@(posedge ref_clk);
		addr <= a;
		rd <= 1'h1;
		@(posedge ref_clk);
		rd <= 1'h0;
		#1;
		r = rdata;
	endtask : rd_reg
	// Three dominant pulses, then idle long enough to restart
	task automatic pat(input int w, input int g);
		repeat (3) begin
			@(posedge ref_clk) bus_dom <= 1'h1;
			repeat (w) @(posedge ref_clk);
			bus_dom <= 1'h0;
			repeat (g) @(posedge ref_clk);
		end
		wt(120);
	endtask : pat
	task automatic t_port;
		rd_reg(STAT_OFS);
		chk(r, 8'h01);
		@(posedge ref_clk) bus_dom <= 1'h1;
		// Two sync stages, pipe and output stage
		wt(4);
		rd_reg(STAT_OFS);
		chk(r, 8'h00);
		bus_dom <= 1'h0;
		wr_reg(4'hC, 8'hFF);
		rd_reg(4'hC);
		chk(r, 8'h00);
		$display("port done");
	endtask : t_port
	task automatic t_slew;
		int d [4];
		for (int s = 0; s < 4; s++) begin
			wr_reg(CTRL_OFS, 8'(s * 2));
			wr_reg(TXD_OFS, 8'h02);
			chk(8'(slew), 8'(s));
			for (i = 0; i < 20 && !drv_dom; i++) wt(1);
			lim(i, 20);
			d[s] = i;
			wr_reg(TXD_OFS, 8'h00);
			wt(12);
			chk(8'(d[s] - d[0]), 8'(s));
			chk(drv_dom, 1'h0);
		end
		$display("slew done");
	endtask : t_slew
	task automatic t_tmo;
		wr_reg(TXD_OFS, 8'h02);
		wt(1950);
		chk(lnk.tx_fail, 1'h0);
		for (i = 0; i < 100 && !lnk.tx_fail; i++) wt(1);
		lim(i, 100);
		// Driver follows the flag one edge later
		wt(1);
		chk(drv_en, 1'h0);
		wr_reg(TXD_OFS, 8'h03);
		wt(10);
		chk({lnk.tx_fail, drv_en}, 8'h01);
		$display("timeout done");
	endtask : t_tmo
	task automatic t_modes;
		chip_mode_t m [7] = '{CHIP_RESET, CHIP_NREQ, CHIP_STANDBY, CHIP_STANDBY, CHIP_STOP,
			CHIP_SLEEP, CHIP_NORMAL};
		logic [6:0] b = 7'h77;
		logic [6:0] e = 7'h48;
		for (int k = 0; k < 7; k++) begin
			@(posedge ref_clk);
			chip_mode <= m[k];
			ext_ballast <= b[k];
			wt(6);
			chk(sup_on, e[k]);
			rd_reg(STAT_OFS);
			chk(r & 8'h01, e[k]);
		end
		$display("modes done");
	endtask : t_modes
	task automatic t_wake;
		int wv [4] = '{5, 45, 10, 30};
		int gv [4] = '{10, 10, 46, 21};
		wr_reg(CTRL_OFS, 8'h01);
		wt(4);
		chk({term, drv_en, wrx}, 8'h04);
		pat(10, 10);
		chk(lnk.wake_flag, 1'h0);
		wr_reg(CTRL_OFS, 8'h09);
		wt(4);
		chk(wrx, 1'h1);
		for (int k = 0; k < 4; k++) begin
			pat(wv[k], gv[k]);
			chk(lnk.wake_flag, 1'h0);
		end
		pat(10, 10);
		chk(lnk.wake_flag, 1'h1);
		rd_reg(STAT_OFS);
		wt(3);
		chk(lnk.wake_flag, 1'h1);
		wr_reg(CTRL_OFS, 8'h08);
		wt(4);
		chk({lnk.wake_flag, bias, term}, 8'h02);
		$display("wake done");
	endtask : t_wake
	task automatic t_report;
		wr_reg(CTRL_OFS, 8'h09);
		@(posedge ref_clk) chip_mode <= CHIP_STOP;
		n = 0;
		fork
			pat(10, 10);
			repeat (200) begin
				wt(1);
				n += int_pulse;
			end
		join
		chk(8'(n), 8'h01);
		@(posedge ref_clk) chip_mode <= CHIP_SLEEP;
		wt(6);
		chk(lsup_on, 1'h0);
		pat(10, 10);
		chk(lsup_on, 1'h1);
		$display("report done");
	endtask : t_report
	initial begin
		ref_clk = 1'h0;
		forever #50 ref_clk = ~ref_clk;
	end
	initial begin
		{rst_n, wr, rd, bus_dom, addr, wdata} = '0;
		ext_ballast = 1'h1;
		chip_mode = CHIP_NORMAL;
		errors = 0;
		checks_done = 0;
		repeat (6) @(posedge ref_clk);
		rst_n <= 1'h1;
		t_port();
		t_slew();
		t_tmo();
		t_modes();
		t_wake();
		t_report();
		final_report();
	end
endmodule : can_transceiver_mode_and_wake_tb
